// file: trd_pkg.sv
// shared constants and carriers for the tape reader drive control
// assumes a 100 MHz system clock and a 32-bit avalon-mm register port
package trd_pkg;

  // timing
  localparam int unsigned CLK_PERIOD_NS    = 10;
  localparam int unsigned SLOW_RATE_CPS    = 200;
  localparam int unsigned FAST_RATE_CPS    = 400;
  localparam int unsigned NS_PER_S         = 1000000000;
  localparam int unsigned SLOW_STEP_CYCLES = NS_PER_S / (SLOW_RATE_CPS * CLK_PERIOD_NS);
  localparam int unsigned FAST_STEP_CYCLES = NS_PER_S / (FAST_RATE_CPS * CLK_PERIOD_NS);
  localparam int unsigned RATE_CNT_W       = 20;

  // register map, byte addresses
  localparam logic [3:0] ADDR_CTRL   = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h4;
  localparam logic [3:0] ADDR_STEPS  = 4'h8;

  // control fields
  localparam int unsigned CTRL_SOFT_HOLD_BIT = 0;
  localparam logic        CTRL_RESET         = 1'b0;

  // status fields
  localparam int unsigned ST_MOVING_BIT  = 0;
  localparam int unsigned ST_DIR_BIT     = 1;
  localparam int unsigned ST_FAST_BIT    = 2;
  localparam int unsigned ST_SYSRDY_BIT  = 3;
  localparam int unsigned ST_DATARDY_BIT = 4;
  localparam int unsigned ST_SPOOL_BIT   = 5;
  localparam int unsigned ST_INHIBIT_BIT = 6;
  localparam int unsigned ST_SEL_LSB     = 8;
  localparam int unsigned ST_SRC_LSB     = 12;

  localparam int unsigned STEP_CNT_W = 16;
  localparam int unsigned SYNC_W     = 11;

  // selector switch encoding on the pins
  localparam logic [1:0] SEL_LOOP  = 2'h0;
  localparam logic [1:0] SEL_LOAD  = 2'h1;
  localparam logic [1:0] SEL_SPOOL = 2'h2;

  typedef enum logic [1:0] {
    TRD_SRC_NONE,
    TRD_SRC_DRIVE,
    TRD_SRC_WIND,
    TRD_SRC_MANUAL
  } trd_src_e;

  // command pins, active low as seen at the connector except selector and end_of_tape
  typedef struct packed {
    logic       hold_off_n;
    logic       drive_right_n;
    logic       drive_left_n;
    logic       wind_enable_n;
    logic       wind_right_n;
    logic       wind_left_n;
    logic [1:0] selector;
    logic       manual_left_n;
    logic       manual_right_n;
    logic       end_of_tape;
  } trd_cmd_s;

  // motion and readiness outputs
  typedef struct packed {
    logic step;
    logic dir_right;
    logic spooler_enable;
    logic system_ready;
    logic data_ready;
  } trd_drive_s;

endpackage

// file: trd_drive_control.sv
// tape reader drive control: motion decision, character rate and ready gating
// assumes asynchronous level command pins and an avalon-mm master on clk_sys
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
module trd_drive_control #(
  parameter int unsigned SLOW_CYCLES = trd_pkg::SLOW_STEP_CYCLES,
  parameter int unsigned FAST_CYCLES = trd_pkg::FAST_STEP_CYCLES
) (
  // clock and reset
  input  wire logic               clk_sys,
  input  wire logic               rst_n,
  // command pins
  input  wire trd_pkg::trd_cmd_s  cmd_pins,
  // drive outputs
  output trd_pkg::trd_drive_s     drive_out,
  // avalon-mm slave
  input  wire logic [3:0]         avs_address,
  input  wire logic               avs_read,
  input  wire logic               avs_write,
  input  wire logic [31:0]        avs_writedata,
  output logic [31:0]             avs_readdata,
  output logic                    avs_waitrequest
);
  import trd_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // two-flop synchronisers
  logic [SYNC_W-1:0] pin_vec;
  logic [SYNC_W-1:0] sync1_reg;
  logic [SYNC_W-1:0] sync2_reg;
  trd_cmd_s          cmd;

  assign pin_vec = cmd_pins;

  generate
    for (genvar i = 0; i < SYNC_W; i++)
    begin : g_sync
      always_ff @(posedge clk_sys or negedge rst_n)
      begin
        if (!rst_n)
        begin
          sync1_reg[i] <= 1'b1;
          sync2_reg[i] <= 1'b1;
        end
        else
        begin
          sync1_reg[i] <= pin_vec[i];
          sync2_reg[i] <= sync1_reg[i];
        end
      end
    end
  endgenerate

  assign cmd = sync2_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // mode decode
  logic      ctrl_hold_reg;
  logic      hold_off;
  logic      dr_req;
  logic      dl_req;
  logic      wind_en;
  logic      wr_req;
  logic      wl_req;
  logic      man_l;
  logic      man_r;
  logic      sel_load;
  logic      inhibit;
  logic      run_req;
  logic      run_right;
  logic      run_fast;
  trd_src_e  src;

  assign hold_off = !cmd.hold_off_n;
  assign dr_req   = !cmd.drive_right_n;
  assign dl_req   = !cmd.drive_left_n;
  assign wind_en  = !cmd.wind_enable_n;
  assign wr_req   = !cmd.wind_right_n;
  assign wl_req   = !cmd.wind_left_n;
  assign man_l    = !cmd.manual_left_n;
  assign man_r    = !cmd.manual_right_n;
  assign sel_load = (cmd.selector != SEL_LOOP) && (cmd.selector != SEL_SPOOL);

  // any inhibit source blocks the drive circuits
  assign inhibit = sel_load || hold_off || cmd.end_of_tape || ctrl_hold_reg;

  always_comb
  begin
    src       = TRD_SRC_NONE;
    run_right = 1'b0;
    run_fast  = 1'b0;
    if (inhibit)
    begin
      src = TRD_SRC_NONE;
    end
    else if (dr_req ^ dl_req)
    begin
      src       = TRD_SRC_DRIVE;
      run_right = dr_req;
      run_fast  = wind_en;
    end
    else if (wind_en && (wr_req ^ wl_req))
    begin
      src       = TRD_SRC_WIND;
      run_right = wr_req;
      run_fast  = 1'b1;
    end
    else if (man_l ^ man_r)
    begin
      src       = TRD_SRC_MANUAL;
      run_right = man_r;
      run_fast  = 1'b1;
    end
    else
    begin
      src = TRD_SRC_NONE;
    end
  end

  assign run_req = (src != TRD_SRC_NONE);

  ////////////////////////////////////////////////////////////////////////////////
  // character rate generator
  localparam logic [RATE_CNT_W-1:0] SLOW_LAST = RATE_CNT_W'(SLOW_CYCLES - 1);
  localparam logic [RATE_CNT_W-1:0] FAST_LAST = RATE_CNT_W'(FAST_CYCLES - 1);

  logic [RATE_CNT_W-1:0] rate_cnt_reg;
  logic [RATE_CNT_W-1:0] rate_last;
  logic                  step_now;

  assign rate_last = run_fast ? FAST_LAST : SLOW_LAST;
  assign step_now  = run_req && (rate_cnt_reg >= rate_last);

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rate_cnt_reg <= SLOW_LAST;
    end
    else if (!run_req)
    begin
      rate_cnt_reg <= SLOW_LAST;
    end
    else if (step_now)
    begin
      rate_cnt_reg <= '0;
    end
    else
    begin
      rate_cnt_reg <= rate_cnt_reg + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // drive outputs
  logic                  step_reg;
  logic                  dir_right_reg;
  logic                  fast_reg;
  logic                  moving_reg;
  logic                  spool_en_reg;
  logic                  sys_rdy_reg;
  logic                  data_rdy_reg;
  trd_src_e              src_reg;
  logic [STEP_CNT_W-1:0] steps_reg;

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      step_reg      <= 1'b0;
      dir_right_reg <= 1'b0;
      fast_reg      <= 1'b0;
      moving_reg    <= 1'b0;
      src_reg       <= TRD_SRC_NONE;
    end
    else
    begin
      step_reg   <= step_now;
      moving_reg <= run_req;
      src_reg    <= src;
      fast_reg   <= run_req && run_fast;
      if (run_req)
      begin
        dir_right_reg <= run_right;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      spool_en_reg <= 1'b0;
      sys_rdy_reg  <= 1'b0;
    end
    else
    begin
      spool_en_reg <= !inhibit && (cmd.selector == SEL_SPOOL);
      sys_rdy_reg  <= !inhibit;
    end
  end

  // data ready marks a character on station, dropped while stepping or inhibited
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      data_rdy_reg <= 1'b0;
    end
    else if (inhibit)
    begin
      data_rdy_reg <= 1'b0;
    end
    else if (step_reg)
    begin
      data_rdy_reg <= 1'b1;
    end
    else if (step_now)
    begin
      data_rdy_reg <= 1'b0;
    end
  end

  assign drive_out.step           = step_reg;
  assign drive_out.dir_right      = dir_right_reg;
  assign drive_out.spooler_enable = spool_en_reg;
  assign drive_out.system_ready   = sys_rdy_reg;
  assign drive_out.data_ready     = data_rdy_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // register port
  logic        ack_reg;
  logic [31:0] rdata_reg;
  logic [31:0] status_word;
  logic        req_new;
  logic        wr_take;
  logic        wr_steps;
  logic        wait_reg;

  // a write lands only at the edge where waitrequest is seen low
  assign req_new  = (avs_read || avs_write) && !ack_reg;
  assign wr_take  = ack_reg && avs_write;
  assign wr_steps = wr_take && (avs_address == ADDR_STEPS);

  always_comb
  begin
    status_word                 = '0;
    status_word[ST_MOVING_BIT]  = moving_reg;
    status_word[ST_DIR_BIT]     = dir_right_reg;
    status_word[ST_FAST_BIT]    = fast_reg;
    status_word[ST_SYSRDY_BIT]  = sys_rdy_reg;
    status_word[ST_DATARDY_BIT] = data_rdy_reg;
    status_word[ST_SPOOL_BIT]   = spool_en_reg;
    status_word[ST_INHIBIT_BIT] = inhibit;
    status_word[ST_SEL_LSB +: 2] = cmd.selector;
    status_word[ST_SRC_LSB +: 2] = src_reg;
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ack_reg   <= 1'b0;
      wait_reg  <= 1'b1;
      rdata_reg <= '0;
    end
    else
    begin
      ack_reg  <= req_new;
      wait_reg <= !req_new;
      if (req_new && avs_read)
      begin
        case (avs_address)
          ADDR_CTRL:   rdata_reg <= {31'h0, ctrl_hold_reg};
          ADDR_STATUS: rdata_reg <= status_word;
          ADDR_STEPS:  rdata_reg <= {16'h0, steps_reg};
          default:     rdata_reg <= '0;
        endcase
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl_hold_reg <= CTRL_RESET;
    end
    else if (wr_take && (avs_address == ADDR_CTRL))
    begin
      ctrl_hold_reg <= avs_writedata[CTRL_SOFT_HOLD_BIT];
    end
  end

  // step counter, write clears; a step in the same cycle loads 1
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      steps_reg <= '0;
    end
    else if (step_now)
    begin
      steps_reg <= wr_steps ? STEP_CNT_W'(1) : steps_reg + 1'b1;
    end
    else if (wr_steps)
    begin
      steps_reg <= '0;
    end
  end

  assign avs_readdata    = rdata_reg;
  assign avs_waitrequest = wait_reg;

endmodule

// file: trd_drive_control_checker.sv
// port checker for the tape reader drive control
// assumes binding onto trd_drive_control
`timescale 1ns/1ps
module trd_drive_control_checker #(
  parameter int unsigned SLOW_CYCLES = 20,
  parameter int unsigned FAST_CYCLES = 10
) (
  // clock and reset
  input wire logic               clk_sys,
  input wire logic               rst_n,
  // pins
  input wire trd_pkg::trd_cmd_s  cmd_pins,
  input wire trd_pkg::trd_drive_s drive_out,
  // bus
  input wire logic [3:0]         avs_address,
  input wire logic               avs_read,
  input wire logic               avs_write,
  input wire logic [31:0]        avs_writedata,
  input wire logic [31:0]        avs_readdata,
  input wire logic               avs_waitrequest
);
  import trd_pkg::*;
  logic       soft_reg;
  logic [7:0] gap_reg;
  logic [7:0] run_reg;
  logic       slow;
  assign slow = cmd_pins.hold_off_n && !cmd_pins.end_of_tape && !soft_reg && !cmd_pins.selector[0]
    && !cmd_pins.drive_right_n && cmd_pins.drive_left_n && cmd_pins.wind_enable_n;
  always_ff @(posedge clk_sys or negedge rst_n)
    if (!rst_n) soft_reg <= 1'b0;
    else if (avs_write && !avs_waitrequest && avs_address == ADDR_CTRL)
      soft_reg <= avs_writedata[CTRL_SOFT_HOLD_BIT];
  always_ff @(posedge clk_sys or negedge rst_n)
    if (!rst_n) gap_reg <= 8'h0;
    else if (drive_out.step) gap_reg <= 8'h1;
    else if (gap_reg != 8'hff) gap_reg <= gap_reg + 8'h1;
  always_ff @(posedge clk_sys or negedge rst_n)
    if (!rst_n) run_reg <= 8'h0;
    else if (!slow) run_reg <= 8'h0;
    else if (run_reg != 8'hff) run_reg <= run_reg + 8'h1;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  a_hold_blocks: assert property (
    !cmd_pins.hold_off_n [*5] |-> !(drive_out.step || drive_out.system_ready
    || drive_out.data_ready))
    else $error("output active under hold-off");
  a_load_blocks: assert property (
    cmd_pins.selector == SEL_LOAD [*5] |-> !(drive_out.step || drive_out.system_ready
    || drive_out.spooler_enable)) else $error("output active in load");
  a_eot_blocks: assert property (
    cmd_pins.end_of_tape [*5] |-> !drive_out.step && !drive_out.system_ready)
    else $error("output active at end of tape");
  a_spool_on: assert property (
    (cmd_pins.selector == SEL_SPOOL && cmd_pins.hold_off_n && !cmd_pins.end_of_tape && !soft_reg)
    [*5] |-> drive_out.spooler_enable && drive_out.system_ready) else $error("spool not enabled");
  a_step_pulse: assert property (
    drive_out.step |=> !drive_out.step [*8]) else $error("step too long or too close");
  a_slow_gap: assert property (
    drive_out.step && run_reg > SLOW_CYCLES + 4 |-> gap_reg == SLOW_CYCLES)
    else $error("slow drive rate wrong");
  a_right_dir: assert property (
    (!cmd_pins.drive_right_n && cmd_pins.drive_left_n) [*4] ##0 drive_out.step
    |-> drive_out.dir_right)
    else $error("drive right went left");
  a_wind_gate: assert property (
    (cmd_pins.wind_enable_n && cmd_pins.drive_right_n && cmd_pins.drive_left_n
    && cmd_pins.manual_left_n && cmd_pins.manual_right_n) [*5] |-> !drive_out.step)
    else $error("wind without enable");
  c_slow: cover property (drive_out.step && run_reg > SLOW_CYCLES + 4);
  c_soft: cover property (soft_reg && !cmd_pins.drive_right_n);
  c_read: cover property (avs_read && !avs_waitrequest);
endmodule
bind trd_drive_control trd_drive_control_checker #(.SLOW_CYCLES(SLOW_CYCLES),
  .FAST_CYCLES(FAST_CYCLES)) i_trd_drive_control_checker (.clk_sys(clk_sys), .rst_n(rst_n),
  .cmd_pins(cmd_pins), .drive_out(drive_out), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest));

// file: trd_cmd_src.sv
// external controller model driving the command pins
// assumes active-high requests from the bench
`timescale 1ns/1ps
module trd_cmd_src (
  // requests, 1 = asserted
  input wire logic [10:0]     req,
  // pins
  output trd_pkg::trd_cmd_s   cmd_pins
);
  import trd_pkg::*;
  // command lines low when asserted, high when negated; selector and end_of_tape pass through uninverted
  assign cmd_pins = req ^ 11'h7e6;
endmodule

// file: trd_drive_control_tb.sv
// self-checking bench for the tape reader drive control
// assumes short step counts and the pin model trd_cmd_src
`timescale 1ns/1ps
module trd_drive_control_tb;
  import trd_pkg::*;
  localparam int S = 20;
  localparam int F = 10;
  localparam logic [10:0] MODES [11] = '{11'h210, 11'h180, 11'h0d0, 11'h0a0, 11'h014,
    11'h002, 11'h600, 11'h208, 11'h211, 11'h050, 11'h302};
  logic        clk_sys = 1'b0;
  logic        rst_n = 1'b0;
  logic [10:0] req = 11'h008;
  logic [3:0]  adr = 4'h0;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic [31:0] wd = 32'h0;
  logic [31:0] rdata;
  logic        wait_rq;
  trd_cmd_s    pins;
  trd_drive_s  dout;
  int          miscompares = 0;
  int          check_count = 0;
  int          nst = 0;
  trd_cmd_src i_trd_cmd_src (.req(req), .cmd_pins(pins));
  trd_drive_control #(.SLOW_CYCLES(S), .FAST_CYCLES(F)) i_trd_drive_control (.clk_sys(clk_sys),
    .rst_n(rst_n), .cmd_pins(pins), .drive_out(dout), .avs_address(adr), .avs_read(rd),
    .avs_write(wr), .avs_writedata(wd), .avs_readdata(rdata), .avs_waitrequest(wait_rq));
  always #5 clk_sys = ~clk_sys;
  always @(negedge clk_sys)
    if (dout.step === 1'b1) nst++;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(string n, logic [31:0] s, logic [31:0] e);
    check_count++;
    if (s !== e)
    begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic bus(logic w, logic [3:0] a, logic [31:0] d, output logic [31:0] q);
    @(posedge clk_sys);
    adr <= a;
    wd <= d;
    wr <= w;
    rd <= !w;
    do @(posedge clk_sys); while (wait_rq !== 1'b0);
    q = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  task automatic wstep(output int k);
    k = 0;
    do
    begin
      @(posedge clk_sys);
      k++;
    end
    while (dout.step !== 1'b1 && k < 60);
  endtask
  // reference model: step interval, direction and source from requests
  function automatic int mdl(logic [10:0] r, output int dir, output int src);
    dir = 0;
    src = 0;
    if (r[10] || r[0] || r[3]) return 0;
    if (r[9] ^ r[8])
    begin
      dir = r[9];
      src = 1;
      return r[7] ? F : S;
    end
    if (r[7] && (r[6] ^ r[5]))
    begin
      dir = r[6];
      src = 2;
      return F;
    end
    if (r[2] ^ r[1])
    begin
      dir = r[1];
      src = 3;
      return F;
    end
    return 0;
  endfunction
  task automatic finish_test;
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    #100000;
    miscompares++;
    finish_test;
  end
  initial
  begin
    logic [31:0] q;
    int          g;
    int          dir;
    int          src;
    int          k;
    logic        ih;
    void'($urandom(66));
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'b1;
    bus(1'b0, ADDR_CTRL, 32'h0, q);
    chk("ctrl reset", q, 32'h0);
    bus(1'b1, 4'hc, $urandom, q);
    bus(1'b0, 4'hc, 32'h0, q);
    chk("unmapped", q, 32'h0);
    bus(1'b1, ADDR_STEPS, $urandom, q);
    for (int m = 0; m < 11; m++)
    begin
      req <= MODES[m];
      repeat (6) @(posedge clk_sys);
      g = mdl(MODES[m], dir, src);
      ih = MODES[m][10] || MODES[m][0] || MODES[m][3];
      chk("system_ready", dout.system_ready, !ih);
      chk("spooler", dout.spooler_enable, !ih && MODES[m][4:3] == 2'h2);
      if (ih) chk("data_ready", dout.data_ready, 1'b0);
      if (g != 0)
      begin
        wstep(k);
        wstep(k);
        chk("gap", k, g);
        chk("dir_right", dout.dir_right, dir);
        @(posedge clk_sys);
        chk("data_ready", dout.data_ready, 1'b1);
        bus(1'b0, ADDR_STATUS, 32'h0, q);
        chk("source", q[13:12], src);
      end
      else
      begin
        k = nst;
        repeat (3 * S) @(posedge clk_sys);
        chk("idle steps", nst - k, 0);
      end
    end
    req <= 11'h200;
    bus(1'b1, ADDR_CTRL, 32'h1, q);
    bus(1'b0, ADDR_CTRL, 32'h0, q);
    chk("ctrl", q, 32'h1);
    k = nst;
    repeat (3 * S) @(posedge clk_sys);
    chk("soft steps", nst - k, 0);
    chk("soft ready", dout.system_ready, 1'b0);
    req <= 11'h600;
    bus(1'b1, ADDR_CTRL, 32'h0, q);
    repeat (6) @(posedge clk_sys);
    bus(1'b0, ADDR_STEPS, 32'h0, q);
    chk("steps", q, nst & 32'hffff);
    finish_test;
  end
endmodule
